//--- sprt_pkg.sv
`default_nettype none
// ==================================================
// Serial port pin routing constants
package sprt_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int PIN_N = 6;
  // Pin-selection register offset and reset value
  localparam logic [ADDR_W-1:0] PINSEL_OFFSET = 4'h0;
  localparam logic [DATA_W-1:0] PINSEL_RESET = 16'h0000;
  // Field positions
  localparam int SP1_LSB = 10;
  localparam int SP0_LSB = 8;
  localparam int RSV_LSB = 6;
  // Writable bits: the two route fields only
  localparam logic [DATA_W-1:0] PINSEL_WMASK = 16'h0f00;
  // Route field encodings
  localparam logic [1:0] ROUTE_CARD = 2'h0;
  localparam logic [1:0] ROUTE_AUDIO = 2'h1;
  localparam logic [1:0] ROUTE_GPIO = 2'h2;
  // Audio occupies the low four pins, gpio the top two in audio mode
  localparam int AUDIO_N = 4;
endpackage
`default_nettype wire

//--- sprt_route.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================
module sprt_route
  import sprt_pkg::*;
(
  input wire logic i_clk, // System clock 20 MHz
  input wire logic i_nrst, // Async reset, active low
  input wire logic [sprt_pkg::ADDR_W-1:0] i_addr, // Register address
  input wire logic [sprt_pkg::DATA_W-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [sprt_pkg::DATA_W-1:0] o_rdata, // Read data, cycle after strobe
  // Peripheral side, port 1
  input wire logic [5:0] i_card1_out, // Card interface 1 pin outputs
  input wire logic [5:0] i_card1_oe, // Card interface 1 enables
  output logic [5:0] o_card1_in, // Card interface 1 pin inputs
  input wire logic [3:0] i_audio1_out, // Audio serial 1 outputs
  input wire logic [3:0] i_audio1_oe, // Audio serial 1 enables
  output logic [3:0] o_audio1_in, // Audio serial 1 inputs
  // Peripheral side, port 0
  input wire logic [5:0] i_card0_out, // Card interface 0 pin outputs
  input wire logic [5:0] i_card0_oe, // Card interface 0 enables
  output logic [5:0] o_card0_in, // Card interface 0 pin inputs
  input wire logic [3:0] i_audio0_out, // Audio serial 0 outputs
  input wire logic [3:0] i_audio0_oe, // Audio serial 0 enables
  output logic [3:0] o_audio0_in, // Audio serial 0 inputs
  // General-purpose pins 11:0
  input wire logic [11:0] i_gp_out, // General-purpose outputs
  input wire logic [11:0] i_gp_oe, // General-purpose enables
  output logic [11:0] o_gp_in, // General-purpose inputs
  // External pads
  input wire logic [5:0] i_sp1_pin, // Port 1 pad levels
  output logic [5:0] o_sp1_pin, // Port 1 pad drive
  output logic [5:0] o_sp1_oe, // Port 1 pad enable
  input wire logic [5:0] i_sp0_pin, // Port 0 pad levels
  output logic [5:0] o_sp0_pin, // Port 0 pad drive
  output logic [5:0] o_sp0_oe, // Port 0 pad enable
  output logic [1:0] o_sp1_mode, // Current port 1 route
  output logic [1:0] o_sp0_mode // Current port 0 route
);
  import sprt_pkg::*;

  logic [DATA_W-1:0] pinsel_reg;
  logic [DATA_W-1:0] pinsel_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  wire sel_hit;
  wire [1:0] serial_port1_route_select;
  wire [1:0] serial_port0_route_select;

  // ==================================================
  // Register access
  assign sel_hit = (i_addr == PINSEL_OFFSET);
  // Only route fields are writable
  assign pinsel_next = (i_wr && sel_hit) ? (i_wdata & PINSEL_WMASK) : pinsel_reg;
  // Unmapped reads return zero
  assign rdata_next = (i_rd && sel_hit) ? pinsel_reg : '0;

  // Register state
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pinsel_reg <= PINSEL_RESET;
      rdata_reg <= '0;
    end else begin
      pinsel_reg <= pinsel_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign serial_port1_route_select = pinsel_reg[SP1_LSB +: 2];
  assign serial_port0_route_select = pinsel_reg[SP0_LSB +: 2];
  assign o_sp1_mode = serial_port1_route_select;
  assign o_sp0_mode = serial_port0_route_select;

  // ==================================================
  // Pin routing, one generate loop over the pins, one block per port inside it
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_pin
      // Port 1 pad drive
      always_comb begin
        case (serial_port1_route_select)
          ROUTE_CARD: begin
            o_sp1_pin[g] = i_card1_out[g];
            o_sp1_oe[g] = i_card1_oe[g];
          end
          ROUTE_AUDIO: begin
            o_sp1_pin[g] = (g < AUDIO_N) ? i_audio1_out[g % AUDIO_N] : i_gp_out[6 + g];
            o_sp1_oe[g] = (g < AUDIO_N) ? i_audio1_oe[g % AUDIO_N] : i_gp_oe[6 + g];
          end
          ROUTE_GPIO: begin
            o_sp1_pin[g] = i_gp_out[6 + g];
            o_sp1_oe[g] = i_gp_oe[6 + g];
          end
          default: begin
            o_sp1_pin[g] = 1'b0;
            o_sp1_oe[g] = 1'b0;
          end
        endcase
      end
      // Port 0 pad drive
      always_comb begin
        case (serial_port0_route_select)
          ROUTE_CARD: begin
            o_sp0_pin[g] = i_card0_out[g];
            o_sp0_oe[g] = i_card0_oe[g];
          end
          ROUTE_AUDIO: begin
            o_sp0_pin[g] = (g < AUDIO_N) ? i_audio0_out[g % AUDIO_N] : i_gp_out[g];
            o_sp0_oe[g] = (g < AUDIO_N) ? i_audio0_oe[g % AUDIO_N] : i_gp_oe[g];
          end
          ROUTE_GPIO: begin
            o_sp0_pin[g] = i_gp_out[g];
            o_sp0_oe[g] = i_gp_oe[g];
          end
          default: begin
            o_sp0_pin[g] = 1'b0;
            o_sp0_oe[g] = 1'b0;
          end
        endcase
      end
      // Input return paths, deselected peripherals see zero
      assign o_card1_in[g] = (serial_port1_route_select == ROUTE_CARD) ? i_sp1_pin[g] : 1'b0;
      assign o_card0_in[g] = (serial_port0_route_select == ROUTE_CARD) ? i_sp0_pin[g] : 1'b0;
      if (g < AUDIO_N) begin : g_aud
        assign o_audio1_in[g] = (serial_port1_route_select == ROUTE_AUDIO) ? i_sp1_pin[g] : 1'b0;
        assign o_audio0_in[g] = (serial_port0_route_select == ROUTE_AUDIO) ? i_sp0_pin[g] : 1'b0;
        assign o_gp_in[6 + g] = (serial_port1_route_select == ROUTE_GPIO) ? i_sp1_pin[g] : 1'b0;
        assign o_gp_in[g] = (serial_port0_route_select == ROUTE_GPIO) ? i_sp0_pin[g] : 1'b0;
      end else begin : g_gp
        assign o_gp_in[6 + g] = (serial_port1_route_select == ROUTE_GPIO ||
            serial_port1_route_select == ROUTE_AUDIO) ? i_sp1_pin[g] : 1'b0;
        assign o_gp_in[g] = (serial_port0_route_select == ROUTE_GPIO ||
            serial_port0_route_select == ROUTE_AUDIO) ? i_sp0_pin[g] : 1'b0;
      end
    end
  endgenerate

  // ==================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_sp1_field_write: assert property (
    i_wr && sel_hit |=> o_sp1_mode == $past(i_wdata[11:10]))
    else $error("port 1 route not taken from bits 11:10");
  chk_sp0_field_write: assert property (
    i_wr && sel_hit |=> o_sp0_mode == $past(i_wdata[9:8]))
    else $error("port 0 route not taken from bits 9:8");
  chk_sp1_card_route: assert property (
    o_sp1_mode == ROUTE_CARD |-> o_sp1_pin == i_card1_out && o_sp1_oe == i_card1_oe)
    else $error("port 1 card route wrong");
  chk_sp1_audio_route: assert property (
    o_sp1_mode == ROUTE_AUDIO |-> o_sp1_pin == {i_gp_out[11:10], i_audio1_out})
    else $error("port 1 audio route wrong");
  chk_sp1_gpio_route: assert property (
    o_sp1_mode == ROUTE_GPIO |-> o_sp1_pin == i_gp_out[11:6] && o_sp1_oe == i_gp_oe[11:6])
    else $error("port 1 gpio route wrong");
  chk_sp0_card_route: assert property (
    o_sp0_mode == ROUTE_CARD |-> o_sp0_pin == i_card0_out && o_card0_in == i_sp0_pin)
    else $error("port 0 card route wrong");
  chk_sp0_audio_route: assert property (
    o_sp0_mode == ROUTE_AUDIO |-> o_sp0_oe == {i_gp_oe[5:4], i_audio0_oe})
    else $error("port 0 audio route wrong");
  chk_sp0_gpio_route: assert property (
    o_sp0_mode == ROUTE_GPIO |-> o_sp0_pin == i_gp_out[5:0] && o_gp_in[5:0] == i_sp0_pin)
    else $error("port 0 gpio route wrong");
  chk_reserved_read_zero: assert property (
    i_rd && sel_hit ##1 1'b1 |-> o_rdata[7:6] == 2'h0 && o_rdata[15:12] == 4'h0)
    else $error("reserved bits read nonzero");
  // Complementary route, input and read-path checks
  chk_sp1_audio_oe: assert property (
    o_sp1_mode == ROUTE_AUDIO |-> o_sp1_oe == {i_gp_oe[11:10], i_audio1_oe})
    else $error("port 1 audio enables wrong");
  chk_sp1_audio_input: assert property (
    o_sp1_mode == ROUTE_AUDIO |-> o_audio1_in == i_sp1_pin[3:0] &&
      o_gp_in[11:10] == i_sp1_pin[5:4])
    else $error("port 1 audio inputs wrong");
  chk_sp0_audio_pins: assert property (
    o_sp0_mode == ROUTE_AUDIO |-> o_sp0_pin == {i_gp_out[5:4], i_audio0_out})
    else $error("port 0 audio pins wrong");
  chk_sp0_card_enable: assert property (
    o_sp0_mode == ROUTE_CARD |-> o_sp0_oe == i_card0_oe)
    else $error("port 0 card enables wrong");
  chk_sp1_card_input: assert property (
    o_sp1_mode == ROUTE_CARD |-> o_card1_in == i_sp1_pin && o_audio1_in == 4'h0)
    else $error("port 1 card input wrong");
  chk_sp0_gpio_enable: assert property (
    o_sp0_mode == ROUTE_GPIO |-> o_sp0_oe == i_gp_oe[5:0] && o_card0_in == 6'h00)
    else $error("port 0 gpio enables wrong");
  chk_sp1_gpio_input: assert property (
    o_sp1_mode == ROUTE_GPIO |-> o_gp_in[11:6] == i_sp1_pin && o_card1_in == 6'h00)
    else $error("port 1 gpio input wrong");
  chk_read_data_value: assert property (
    i_rd && sel_hit |=> o_rdata == {4'h0, $past(o_sp1_mode), $past(o_sp0_mode), 8'h00})
    else $error("read data differs from route fields");
  chk_other_write_ignored: assert property (
    i_wr && !sel_hit |=> $stable(o_sp1_mode) && $stable(o_sp0_mode))
    else $error("write to other address changed a route");
  chk_read_idle_zero: assert property (
    !i_rd |=> o_rdata == 16'h0000)
    else $error("read data not cleared after read");

  cov_sp1_audio: cover property (i_wr && sel_hit && i_wdata[11:10] == ROUTE_AUDIO);
  cov_sp0_gpio: cover property (i_wr && sel_hit && i_wdata[9:8] == ROUTE_GPIO);
  cov_read_back: cover property (i_wr && sel_hit ##1 i_rd && sel_hit);
  cov_mode_change: cover property (o_sp0_mode == ROUTE_CARD ##1 o_sp0_mode == ROUTE_AUDIO);
  cov_sp1_gpio: cover property (o_sp1_mode == ROUTE_GPIO && o_sp0_mode == ROUTE_CARD);
endmodule // sprt_route
`default_nettype wire

//--- test_serial_port_pin_routing.sv
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// Routing bench: register accesses and pad mapping
module test_serial_port_pin_routing;
  import sprt_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [ADDR_W-1:0] i_addr = 4'h0;
  logic [DATA_W-1:0] i_wdata = 16'h0000, o_rdata;
  logic [5:0] c1o = 6'h00, c1e = 6'h00, c0o = 6'h00, c0e = 6'h00, s1i = 6'h00, s0i = 6'h00;
  logic [3:0] a1o = 4'h0, a1e = 4'h0, a0o = 4'h0, a0e = 4'h0, a1i, a0i, mode_reg = 4'h0;
  logic [11:0] gpo = 12'h000, gpe = 12'h000, gpi;
  logic [5:0] c1i, c0i, s1p, s1e, s0p, s0e;
  logic [1:0] m1, m0;
  logic [63:0] rd_q[$], pad_q[$];
  int n_mismatch = 0, cmp_count = 0;
  integer seed = 32'h84fe;
  logic [63:0] pad_seen;
  sprt_route u_sprt_route (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_card1_out(c1o), .i_card1_oe(c1e),
    .o_card1_in(c1i), .i_audio1_out(a1o), .i_audio1_oe(a1e), .o_audio1_in(a1i),
    .i_card0_out(c0o), .i_card0_oe(c0e), .o_card0_in(c0i), .i_audio0_out(a0o),
    .i_audio0_oe(a0e), .o_audio0_in(a0i), .i_gp_out(gpo), .i_gp_oe(gpe), .o_gp_in(gpi),
    .i_sp1_pin(s1i), .o_sp1_pin(s1p), .o_sp1_oe(s1e), .i_sp0_pin(s0i), .o_sp0_pin(s0p),
    .o_sp0_oe(s0e), .o_sp1_mode(m1), .o_sp0_mode(m0));
  // Clock at 50 ns
  always #25 i_clk = ~i_clk;
  // Observed port outputs in note order
  assign pad_seen = {4'h0, m1, s1p, s1e, c1i, a1i, gpi[11:6], m0, s0p, s0e, c0i, a0i, gpi[5:0]};
  // ==================================================
  // Expected mode, pads and peripheral inputs of one port
  function automatic logic [29:0] port_exp(input logic [1:0] m, input logic [5:0] co, ce, pin,
    input logic [3:0] ao, ae, input logic [5:0] go, ge);
    case (m)
      2'h0: return {m, co, ce, pin, 4'h0, 6'h00};
      2'h1: return {m, go[5:4], ao, ge[5:4], ae, 6'h00, pin[3:0], pin[5:4], 4'h0};
      2'h2: return {m, go, ge, 6'h00, 4'h0, pin};
      default: return {m, 28'h0};
    endcase
  endfunction
  // Compare and count
  task automatic check(input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus access with fresh random peripheral levels, expectations queued
  task automatic acc(input logic w, r, input logic [3:0] a, input logic [15:0] d);
    logic [63:0] rv;
    logic [31:0] rw;
    rv = {$random(seed), $random(seed)};
    rw = $random(seed);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    {c1o, c1e, c0o, c0e, s1i, s0i} <= rv[35:0];
    {a1o, a1e, a0o, a0e, gpo} <= rw[27:0];
    gpe <= rv[47:36];
    @(posedge i_clk);
    if (w && a == PINSEL_OFFSET) mode_reg = d[11:8];
    if (r) rd_q.push_back({48'h0, (a == PINSEL_OFFSET) ? {4'h0, mode_reg, 8'h00} : 16'h0000});
    pad_q.push_back({4'h0, port_exp(mode_reg[3:2], c1o, c1e, s1i, a1o, a1e, gpo[11:6],
      gpe[11:6]), port_exp(mode_reg[1:0], c0o, c0e, s0i, a0o, a0e, gpo[5:0], gpe[5:0])});
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==================================================
  // Monitor: settled outputs against oldest notes
  always @(negedge i_clk) begin
    if (rd_q.size() > 0) check({48'h0, o_rdata}, rd_q.pop_front());
    if (pad_q.size() > 0) check(pad_seen, pad_q.pop_front());
  end
  // Main sequence: every legal code pair, reserved bits, unmapped places, reset
  initial begin
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    acc(0, 1, 4'h0, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      acc(1, 0, 4'h0, 16'($random(seed)) & 16'hf0ff | {4'h0, 2'(i / 3), 2'(i % 3), 8'h00});
      acc(0, 1, 4'h0, 16'h0000);
      acc(1, 0, 4'h1 + 4'(i), 16'hffff);
      acc(0, 1, 4'h1 + 4'(i), 16'h0000);
    end
    @(posedge i_clk);
    i_nrst <= 1'b0;
    mode_reg = 4'h0;
    @(posedge i_clk);
    i_nrst <= 1'b1;
    acc(0, 1, 4'h0, 16'h0000);
    report_and_stop;
  end
  // Watchdog against a hang
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop;
  end
endmodule // test_serial_port_pin_routing
`default_nettype wire
